// *** core/rrso_pkg.sv ***
// Shared constants, types and helpers for the byte rotate and set execution block.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit data path with 12-bit data addresses.
package rrso_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] RRSO_OFF_CTRL = 8'h00;
    localparam logic [7:0] RRSO_OFF_INSTR = 8'h04;
    localparam logic [7:0] RRSO_OFF_ACC = 8'h08;
    localparam logic [7:0] RRSO_OFF_BANK = 8'h0C;
    localparam logic [7:0] RRSO_OFF_STATUS = 8'h10;
    localparam logic [7:0] RRSO_OFF_INDEX = 8'h14;
    localparam logic [7:0] RRSO_OFF_MADDR = 8'h18;
    localparam logic [7:0] RRSO_OFF_MDATA = 8'h1C;

    // Field positions
    localparam int RRSO_CTRL_EXT_BIT = 0;
    localparam int RRSO_ST_CARRY_BIT = 0;
    localparam int RRSO_ST_ZERO_BIT = 1;
    localparam int RRSO_ST_NEG_BIT = 2;
    localparam int RRSO_ST_BUSY_BIT = 8;
    localparam int RRSO_OP_DEST_BIT = 9;
    localparam int RRSO_OP_ACCESS_BIT = 8;

    // Reset values
    localparam logic [7:0] RRSO_ACC_RST = 8'h00;
    localparam logic [3:0] RRSO_BANK_RST = 4'h0;
    localparam logic [11:0] RRSO_INDEX_RST = 12'h000;
    localparam logic [11:0] RRSO_MADDR_RST = 12'h000;

    // Opcode patterns (upper bits of the 16-bit instruction word)
    localparam logic [5:0] RRSO_PAT_ROT_NC = 6'h10;
    localparam logic [5:0] RRSO_PAT_ROT_C = 6'h0C;
    localparam logic [6:0] RRSO_PAT_SET = 7'h34;

    // Address map constants
    localparam logic [7:0] RRSO_INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] RRSO_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] RRSO_SFR_BANK = 4'hF;
    localparam logic [7:0] RRSO_ALL_ONES = 8'hFF;

    // Execution phases, Gray coded along the usual path
    typedef enum logic [2:0] {
        RRSO_IDLE = 3'h0,
        RRSO_DECODE = 3'h1,
        RRSO_READ = 3'h3,
        RRSO_PROCESS = 3'h2,
        RRSO_WRITE = 3'h6
    } rrso_phase_type;

    // Operation class
    typedef enum logic [1:0] {
        RRSO_K_NONE = 2'h0,
        RRSO_K_ROT_NC = 2'h1,
        RRSO_K_ROT_C = 2'h2,
        RRSO_K_SET = 2'h3
    } rrso_kind_type;

    // Opcode decode, used only by the decode phase
    function automatic rrso_kind_type rrso_decode(input logic [15:0] op);
        rrso_kind_type k;
        k = RRSO_K_NONE;
        if (op[15:10] == RRSO_PAT_ROT_NC)
            k = RRSO_K_ROT_NC;
        else if (op[15:10] == RRSO_PAT_ROT_C)
            k = RRSO_K_ROT_C;
        else if (op[15:9] == RRSO_PAT_SET)
            k = RRSO_K_SET;
        return k;
    endfunction : rrso_decode

    // Rotate right, carry in on top
    function automatic logic [7:0] rrso_rot_right(input logic [7:0] x, input logic top);
        return {top, x[7:1]};
    endfunction : rrso_rot_right

endpackage : rrso_pkg

// *** core/rrso_file_mem.sv ***
// Byte-wide file register memory with one write port and one registered read port.
// Assumes a single clock; read data appear one edge after the read address.
`timescale 1ns/1ps
module rrso_file_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    import rrso_pkg::*;

    // Storage, left without reset as real file RAM would be
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write on the edge
    always_ff @(posedge hclk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    // Registered read; a write to the same address shows on the next read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata <= '0;
        else
            rdata <= mem[raddr];
    end

endmodule : rrso_file_mem

// *** core/rrso_addr_unit.sv ***
// Effective address generation for byte-oriented file operands.
// Assumes purely combinational use inside the execution block.
`timescale 1ns/1ps
module rrso_addr_unit (
    // Operand fields
    input wire logic [7:0] f,
    input wire logic access_sel,
    // Address context
    input wire logic ext_en,
    input wire logic [3:0] bank_pointer,
    input wire logic [11:0] index_base,
    // Result
    output logic [11:0] eff_addr,
    output logic indexed
);
    import rrso_pkg::*;

    // Bank choice and indexed literal offset
    always_comb
    begin
        indexed = 1'b0;
        if (access_sel)
            eff_addr = {bank_pointer, f};
        else if (ext_en && (f <= RRSO_INDEX_LIMIT))
        begin
            eff_addr = 12'(index_base + {4'h0, f});
            indexed = 1'b1;
        end
        // Fast-access bank: low part in bank 0, high part in special bank
        else if (f < RRSO_ACCESS_SPLIT)
            eff_addr = {4'h0, f};
        else
            eff_addr = {RRSO_SFR_BANK, f};
    end

endmodule : rrso_addr_unit

// *** core/rrso_core.sv ***
// Execution block for rotate right (no carry), rotate right through carry and set-all-ones.
// Assumes a single AHB-Lite master, zero wait states, whole-word single transfers.
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module rrso_core #(
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave request
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // AHB-Lite slave answer
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    import rrso_pkg::*;

    // All state of the block
    typedef struct packed {
        rrso_phase_type phase;   // Execution phase
        logic [15:0] op;         // Instruction under execution
        rrso_kind_type kind;     // Decoded class
        logic [11:0] ea;         // Effective file address
        logic [7:0] res;         // Result held for the write phase
        logic carry_new;         // Carry held for the write phase
        logic [7:0] acc;         // Accumulator
        logic [3:0] bank;        // Bank pointer
        logic carry;             // Status flags
        logic zero;
        logic neg;
        logic ext_en;            // Extended instruction set enable
        logic [11:0] index;      // Index base for literal offset mode
        logic [11:0] maddr;      // Software pointer into file memory
        logic wr_pend;           // Write data phase pending
        logic [7:0] wr_off;      // Offset of pending write
        logic [31:0] rdata;      // Read data for the data phase
        logic readyout;          // Bus ready
        logic resp;              // Bus response, kept in a flop so every output is registered
    } rrso_state_type;

    rrso_state_type q_r;    // Registered state
    rrso_state_type q_nxt;  // Next state

    // Memory and address unit wiring
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [11:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic [11:0] calc_ea;

    // Operand fields of the held instruction
    logic op_dest;
    logic op_access;
    assign op_dest = q_r.op[RRSO_OP_DEST_BIT];
    assign op_access = q_r.op[RRSO_OP_ACCESS_BIT];

    // File register storage
    rrso_file_mem #(
        .AW(AW),
        .DW(8)
    ) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // Effective address from the held instruction
    // access bit bank select
    rrso_addr_unit u_addr (
        .f(q_r.op[7:0]),
        .access_sel(op_access),
        .ext_en(q_r.ext_en),
        .bank_pointer(q_r.bank),
        .index_base(q_r.index),
        .eff_addr(calc_ea),
        .indexed()
    );

    // Memory read source: execution owns it while busy, software otherwise
    always_comb
    begin
        if (q_r.phase != RRSO_IDLE)
            mem_raddr = q_r.ea;
        else
            mem_raddr = q_r.maddr;
    end

    // Memory write arbitration: execution result, else a software data write
    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = q_r.maddr;
        mem_wdata = hwdata[7:0];
        if (q_r.phase == RRSO_WRITE)
        begin
            if ((q_r.kind == RRSO_K_SET) || ((q_r.kind != RRSO_K_NONE) && op_dest))
            begin
                mem_we = 1'b1;
                mem_waddr = q_r.ea;
                mem_wdata = q_r.res;
            end
        end
        else if (q_r.phase == RRSO_IDLE && q_r.wr_pend && q_r.wr_off == RRSO_OFF_MDATA)
            mem_we = 1'b1;
    end

    // Next state: bus decode, register writes and the execution sequence
    always_comb
    begin
        logic take;
        logic busy;
        logic [7:0] rot;
        take = 1'b0;
        busy = 1'b0;
        rot = 8'h00;
        q_nxt = q_r;
        busy = (q_r.phase != RRSO_IDLE);
        take = hsel && hready && htrans[1];
        q_nxt.readyout = 1'b1;
        q_nxt.resp = 1'b0;

        // Address phase: latch write target, prepare read data
        q_nxt.wr_pend = take && hwrite;
        if (take)
            q_nxt.wr_off = haddr[7:0];
        if (take && !hwrite)
        begin
            case (haddr[7:0])
                RRSO_OFF_CTRL:
                    q_nxt.rdata = {31'h0, q_r.ext_en};
                RRSO_OFF_INSTR:
                    q_nxt.rdata = {16'h0, q_r.op};
                RRSO_OFF_ACC:
                    q_nxt.rdata = {24'h0, q_r.acc};
                RRSO_OFF_BANK:
                    q_nxt.rdata = {28'h0, q_r.bank};
                RRSO_OFF_STATUS:
                    q_nxt.rdata = {23'h0, busy, 5'h0, q_r.neg, q_r.zero, q_r.carry};
                RRSO_OFF_INDEX:
                    q_nxt.rdata = {20'h0, q_r.index};
                RRSO_OFF_MADDR:
                    q_nxt.rdata = {20'h0, q_r.maddr};
                RRSO_OFF_MDATA:
                    q_nxt.rdata = {24'h0, mem_rdata};
                // Unmapped offsets read as zero
                default:
                    q_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Data phase of a write; state touched by execution is locked while busy
        if (q_r.wr_pend)
        begin
            case (q_r.wr_off)
                RRSO_OFF_CTRL:
                    if (!busy)
                        q_nxt.ext_en = hwdata[RRSO_CTRL_EXT_BIT];
                RRSO_OFF_INSTR:
                    // Starting a new instruction is only possible when idle
                    if (!busy)
                    begin
                        q_nxt.op = hwdata[15:0];
                        q_nxt.phase = RRSO_DECODE;
                    end
                RRSO_OFF_ACC:
                    if (!busy)
                        q_nxt.acc = hwdata[7:0];
                RRSO_OFF_BANK:
                    if (!busy)
                        q_nxt.bank = hwdata[3:0];
                RRSO_OFF_STATUS:
                    if (!busy)
                    begin
                        q_nxt.carry = hwdata[RRSO_ST_CARRY_BIT];
                        q_nxt.zero = hwdata[RRSO_ST_ZERO_BIT];
                        q_nxt.neg = hwdata[RRSO_ST_NEG_BIT];
                    end
                RRSO_OFF_INDEX:
                    if (!busy)
                        q_nxt.index = hwdata[11:0];
                RRSO_OFF_MADDR:
                    if (!busy)
                        q_nxt.maddr = hwdata[11:0];
                // Data writes go straight to memory, other offsets are dropped
                default:
                    q_nxt.maddr = q_r.maddr;
            endcase
        end

        // Execution: decode, read, process, write, one phase per clock
        // four phase sequence
        case (q_r.phase)
            RRSO_IDLE:
                q_nxt.ea = q_r.ea;
            RRSO_DECODE:
            begin
                q_nxt.kind = rrso_decode(q_r.op);
                q_nxt.ea = calc_ea;
                q_nxt.phase = RRSO_READ;
            end
            RRSO_READ:
                // Memory read address is the effective address this cycle
                q_nxt.phase = RRSO_PROCESS;
            RRSO_PROCESS:
            begin
                q_nxt.carry_new = q_r.carry;
                case (q_r.kind)
                    RRSO_K_ROT_NC:
                    begin
                        rot = rrso_rot_right(mem_rdata, mem_rdata[0]);
                        q_nxt.res = rot;
                    end
                    RRSO_K_ROT_C:
                    begin
                        rot = rrso_rot_right(mem_rdata, q_r.carry);
                        q_nxt.res = rot;
                        q_nxt.carry_new = mem_rdata[0];
                    end
                    RRSO_K_SET:
                        q_nxt.res = RRSO_ALL_ONES;
                    default:
                        q_nxt.res = mem_rdata;
                endcase
                q_nxt.phase = RRSO_WRITE;
            end
            RRSO_WRITE:
            begin
                if ((q_r.kind == RRSO_K_ROT_NC || q_r.kind == RRSO_K_ROT_C) && !op_dest)
                    q_nxt.acc = q_r.res;
                if (q_r.kind == RRSO_K_ROT_NC || q_r.kind == RRSO_K_ROT_C)
                begin
                    q_nxt.zero = (q_r.res == 8'h00);
                    q_nxt.neg = q_r.res[7];
                end
                if (q_r.kind == RRSO_K_ROT_C)
                    q_nxt.carry = q_r.carry_new;
                q_nxt.phase = RRSO_IDLE;
            end
            default:
                q_nxt.phase = RRSO_IDLE;
        endcase
    end

    // Single register stage for all state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q_r <= '{
                phase: RRSO_IDLE,
                op: 16'h0000,
                kind: RRSO_K_NONE,
                ea: 12'h000,
                res: 8'h00,
                carry_new: 1'b0,
                acc: RRSO_ACC_RST,
                bank: RRSO_BANK_RST,
                carry: 1'b0,
                zero: 1'b0,
                neg: 1'b0,
                ext_en: 1'b0,
                index: RRSO_INDEX_RST,
                maddr: RRSO_MADDR_RST,
                wr_pend: 1'b0,
                wr_off: 8'h00,
                rdata: 32'h0000_0000,
                readyout: 1'b1,
                resp: 1'b0
            };
        end
        else
            q_r <= q_nxt;
    end

    // Bus outputs straight from state flops; response is always OKAY
    assign hreadyout = q_r.readyout;
    assign hrdata = q_r.rdata;
    assign hresp = q_r.resp;

endmodule : rrso_core

// *** testbench/rrso_core_props.sv ***
// Bus-side checker for the byte rotate and set block.
// Assumes one master, zero wait states and a 4-phase execution.
`timescale 1ns/1ps
module rrso_core_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Answer
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp
);
    import rrso_pkg::*;
    // Data phase trackers and a busy mirror
    logic rd_r, wr_r, bhi_r, blo_r;
    logic [7:0] off_r;
    logic [2:0] busy_r;
    logic take;
    assign take = hsel & hready & htrans[1];
    // Busy mirror counts the four execution phases
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            bhi_r <= 1'b0;
            blo_r <= 1'b0;
            off_r <= 8'h00;
            busy_r <= 3'h0;
        end
        else
        begin
            rd_r <= take & ~hwrite;
            wr_r <= take & hwrite;
            if (take)
            begin
                off_r <= haddr[7:0];
                bhi_r <= busy_r >= 3'h2;
                blo_r <= busy_r == 3'h0;
            end
            if (wr_r && off_r == RRSO_OFF_INSTR && busy_r == 3'h0)
                busy_r <= 3'h4;
            else if (busy_r != 3'h0)
                busy_r <= busy_r - 3'h1;
        end
    end
    property p_ready_high;
        @(posedge hclk) disable iff (!hresetn) hreadyout;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("wait state seen");
    property p_resp_okay;
        @(posedge hclk) disable iff (!hresetn) take |-> ##1 !hresp [*2];
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("error response");
    property p_busy_set;
        @(posedge hclk) disable iff (!hresetn) rd_r && bhi_r && off_r == RRSO_OFF_STATUS |-> hrdata[8];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy missing");
    property p_busy_clear;
        @(posedge hclk) disable iff (!hresetn) rd_r && blo_r && off_r == RRSO_OFF_STATUS |-> !hrdata[8];
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");
    property p_acc_width;
        @(posedge hclk) disable iff (!hresetn) rd_r && off_r == RRSO_OFF_ACC |-> hrdata[31:8] == 24'h0;
    endproperty
    a_acc_width: assert property (p_acc_width) else $error("accumulator upper bits");
    property p_status_bits;
        @(posedge hclk) disable iff (!hresetn)
            rd_r && off_r == RRSO_OFF_STATUS |-> hrdata[31:9] == 23'h0 && hrdata[7:3] == 5'h0;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status spare bits");
    property p_bank_width;
        @(posedge hclk) disable iff (!hresetn) rd_r && off_r == RRSO_OFF_BANK |-> hrdata[31:4] == 28'h0;
    endproperty
    a_bank_width: assert property (p_bank_width) else $error("bank upper bits");
    property p_hold;
        @(posedge hclk) disable iff (!hresetn) !(take && !hwrite) |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : rrso_core_props
bind rrso_core rrso_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

// *** testbench/rrso_core_tb.sv ***
// Self-checking bench for the byte rotate and set block.
// Assumes a zero-wait slave; the bench is the only bus master.
`timescale 1ns/1ps
module rrso_core_tb;
    import rrso_pkg::*;
    // Bus
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fails, total_checks;
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;
    rrso_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // Bounded wait for ready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                fails++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask : wait_ready
    // One single transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : xfer
    // Poll busy under a bound
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
            n++;
        end while (rd[8] !== 1'b0 && n < 20);
        if (rd[8] !== 1'b0)
        begin
            fails++;
            summarize();
        end
    endtask : wait_idle
    task automatic run(input logic [15:0] op);
        xfer(1'b1, RRSO_OFF_INSTR, {16'h0, op});
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd[8], 1'b1);
        wait_idle();
    endtask : run
    task automatic mset(input logic [11:0] a, input logic [7:0] v);
        xfer(1'b1, RRSO_OFF_MADDR, {20'h0, a});
        xfer(1'b1, RRSO_OFF_MDATA, {24'h0, v});
    endtask : mset
    // Pointer write, one idle cycle, then the byte read
    task automatic mget(input logic [11:0] a);
        xfer(1'b1, RRSO_OFF_MADDR, {20'h0, a});
        @(posedge hclk);
        xfer(1'b0, RRSO_OFF_MDATA, 32'h0);
    endtask : mget
    task automatic t_reset;
        logic [7:0] offs [6] = '{RRSO_OFF_CTRL, RRSO_OFF_ACC, RRSO_OFF_BANK, RRSO_OFF_STATUS, RRSO_OFF_INDEX, 8'h40};
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        foreach (offs[i])
        begin
            xfer(1'b0, offs[i], 32'h0);
            check(rd, 32'h0);
        end
    endtask : t_reset
    task automatic t_rot_nc;
        xfer(1'b1, RRSO_OFF_BANK, 32'h3);
        xfer(1'b1, RRSO_OFF_STATUS, 32'h1);
        mset(12'h320, 8'hD7);
        run(16'h4320);
        mget(12'h320);
        check(rd, 32'hEB);
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd, 32'h5);
        mset(12'h020, 8'h01);
        run(16'h4220);
        mget(12'h020);
        check(rd, 32'h80);
        mget(12'h320);
        check(rd, 32'hEB);
        xfer(1'b1, RRSO_OFF_ACC, 32'h55);
        mset(12'hF70, 8'h00);
        run(16'h4070);
        xfer(1'b0, RRSO_OFF_ACC, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd, 32'h3);
        mget(12'hF70);
        check(rd, 32'h0);
    endtask : t_rot_nc
    task automatic t_rot_c;
        xfer(1'b1, RRSO_OFF_STATUS, 32'h0);
        mset(12'h3A5, 8'hE6);
        run(16'h31A5);
        xfer(1'b0, RRSO_OFF_ACC, 32'h0);
        check(rd, 32'h73);
        xfer(1'b1, RRSO_OFF_STATUS, 32'h1);
        run(16'h33A5);
        mget(12'h3A5);
        check(rd, 32'hF3);
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd, 32'h4);
        run(16'h33A5);
        mget(12'h3A5);
        check(rd, 32'h79);
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd, 32'h1);
    endtask : t_rot_c
    // Set opcode is 0110_100a: 69h with the bank pointer, 68h with the fast bank
    task automatic t_set;
        xfer(1'b1, RRSO_OFF_STATUS, 32'h7);
        xfer(1'b1, RRSO_OFF_BANK, 32'h5);
        xfer(1'b1, RRSO_OFF_ACC, 32'h3C);
        mset(12'h544, 8'h5A);
        run(16'h6944);
        mget(12'h544);
        check(rd, 32'hFF);
        xfer(1'b0, RRSO_OFF_STATUS, 32'h0);
        check(rd, 32'h7);
        xfer(1'b0, RRSO_OFF_ACC, 32'h0);
        check(rd, 32'h3C);
        mset(12'h044, 8'h12);
        run(16'h6844);
        mget(12'h044);
        check(rd, 32'hFF);
    endtask : t_set
    task automatic t_index;
        xfer(1'b1, RRSO_OFF_CTRL, 32'h1);
        xfer(1'b1, RRSO_OFF_INDEX, 32'h200);
        mset(12'h25F, 8'h04);
        run(16'h425F);
        mget(12'h25F);
        check(rd, 32'h02);
        mset(12'hF60, 8'h08);
        run(16'h4260);
        mget(12'hF60);
        check(rd, 32'h04);
        mset(12'h210, 8'h00);
        run(16'h6810);
        mget(12'h210);
        check(rd, 32'hFF);
        xfer(1'b1, RRSO_OFF_CTRL, 32'h0);
    endtask : t_index
    // Write landing while busy must be dropped
    task automatic t_refuse;
        xfer(1'b1, RRSO_OFF_ACC, 32'h11);
        xfer(1'b1, RRSO_OFF_INSTR, 32'h6810);
        xfer(1'b1, RRSO_OFF_ACC, 32'h99);
        wait_idle();
        xfer(1'b0, RRSO_OFF_ACC, 32'h0);
        check(rd, 32'h11);
    endtask : t_refuse
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fails = 0;
        total_checks = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_rot_nc();
        t_rot_c();
        t_set();
        t_index();
        t_refuse();
        summarize();
    end
endmodule : rrso_core_tb
